// file: src/mcr_pkg.sv
// Purpose: shared constants for the command/response packet ends
// Assumes: one clock, synchronous active-low reset
// Notes: field positions and status codes of the 32-bit words
package mcr_pkg;
  localparam int CMD_USED_W = 28;
  localparam int RSP_USED_W = 26;
  localparam int RW_BIT = 24;
  localparam int REG_HI = 23;
  localparam int REG_LO = 16;
  localparam int DATA_HI = 15;
  localparam int STAT_HI = 25;
  localparam int STAT_LO = 24;
  localparam int CKS_HI = 31;
  localparam int CKS_LO = 28;
  localparam int PEND_SLOTS = 8;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_AUTO_EXT_ACCESS = 8'h0b;
  localparam logic [7:0] REG_AEA_FIRST = 8'h01;
  localparam logic [7:0] REG_AEA_LAST = 8'h07;
  localparam logic [15:0] ID_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  // host register offsets (byte addresses)
  localparam logic [7:0] HOFF_CMD = 8'h00;
  localparam logic [7:0] HOFF_RSP = 8'h04;
  localparam logic [7:0] HOFF_STAT = 8'h08;
  localparam logic [7:0] HOFF_IEN = 8'h0c;
  localparam logic [7:0] HOFF_ICLR = 8'h10;
  typedef enum logic [1:0] {
    MCR_ST_OK = 2'h0,
    MCR_ST_EXEC_ERR = 2'h1,
    MCR_ST_AUTO_EXT = 2'h2,
    MCR_ST_PENDING = 2'h3
  } mcr_status_t;

  // checksum: xor of four bytes with bits 31:28 cleared, then fold nibbles
  function automatic logic [3:0] mcr_cks(input logic [31:0] w);
    logic [7:0] b;
    b = {4'h0, w[27:24]} ^ w[23:16] ^ w[15:8] ^ w[7:0];
    return b[7:4] ^ b[3:0];
  endfunction
endpackage

// file: src/mcr_if.sv
// Purpose: word link between host end and module end
// Assumes: both ends on clk
// Notes: one word per valid pulse each way
interface mcr_if;
  logic cmd_valid;
  logic [31:0] cmd_word;
  logic rsp_valid;
  logic [31:0] rsp_word;
  modport host (output cmd_valid, output cmd_word,
    input rsp_valid, input rsp_word);
  modport dev (input cmd_valid, input cmd_word,
    output rsp_valid, output rsp_word);
endinterface

// file: src/mcr_dev.sv
// Purpose: module end; decodes commands, builds responses
// Assumes: user side executes commands and reports results
// Notes: pending ids are one-hot slots freed by the user side
//
// Chosen here: the register addresses and the AHB-Lite slave port.
import mcr_pkg::*;

// Notes on behaviour
// - command content sits in low 28 bits
// - bit24 write, 23:16 register, 15:0 data
// - response uses low 26 bits only; here frame bits also fill 27:26
// - status codes ok, error, auto-ext, pending
// - ok only without error or auto-ext
// - error code when execution failed
// - auto-ext returns byte count in data
// - pending answered in time, work continues
// - host polls register 0 for completion
// - pending: low byte zero, one id bit
// - auto-ext write may carry pending id
// - host repeats auto-ext write to access register
// - four-bit checksum folded from byte xor
// - register 0x0b reaches auto-ext location
module mcr_dev import mcr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  mcr_if.dev link,
  output logic req_valid,
  output logic req_write,
  output logic [7:0] req_reg,
  output logic [15:0] req_data,
  output logic [7:0] req_pend_id,
  output logic cks_err,
  input wire logic res_valid,
  input wire logic res_error,
  input wire logic res_pending,
  input wire logic res_auto_ext,
  input wire logic [15:0] res_data,
  input wire logic [7:0] pend_done,
  output logic [7:0] pend_busy
);
  // state held between command and result
  logic [31:0] rsp_reg;
  logic rsp_valid_reg;
  logic [7:0] busy_reg;
  logic [7:0] busy_next;
  logic [7:0] req_reg_reg;
  logic [7:0] pend_id_reg;
  logic wait_reg;
  logic [31:0] last_rsp_reg;

  ////////////////////////////////////////////////////////////////
  // command decode
  // the word is only looked at while the end is idle
  // and the clock enable is high
  // resend asks for a replay of the last answer
  wire [31:0] cw = link.cmd_word;
  wire cks_ok = (cw[CKS_HI:CKS_LO] == mcr_cks(cw));
  wire resend = cw[27]; // resend_request_bit
  wire cmd_take = ce && link.cmd_valid && !wait_reg;
  wire cmd_good = cmd_take && cks_ok && !resend;
  wire is_write = cw[RW_BIT];
  wire [7:0] cmd_reg = cw[REG_HI:REG_LO];
  wire [15:0] cmd_data = cw[DATA_HI:0];

  ////////////////////////////////////////////////////////////////
  // lowest free pending slot, one-hot
  // a slot stays taken until the user side frees it,
  // so two open operations never share an id
  wire [7:0] free_slots = ~busy_reg;
  wire [7:0] free_pick = free_slots & (~free_slots + 8'h01);
  wire slot_free = (free_pick != 8'h00);

  ////////////////////////////////////////////////////////////////
  // response status selection
  // error beats auto-ext, auto-ext beats pending;
  // with every slot taken a pending result reads as ok
  wire res_take = ce && wait_reg && res_valid;
  wire use_pend = res_pending && slot_free;
  mcr_status_t st;
  assign st = res_error ? MCR_ST_EXEC_ERR :
    res_auto_ext ? MCR_ST_AUTO_EXT :
    use_pend ? MCR_ST_PENDING :
    MCR_ST_OK;

  // data field: id for pending, count for auto-ext
  wire [15:0] rsp_data =
    (st == MCR_ST_PENDING) ? {free_pick, 8'h00} :
    (st == MCR_ST_AUTO_EXT && use_pend) ?
      {free_pick, res_data[7:0]} :
    res_data;

  ////////////////////////////////////////////////////////////////
  // framing of the outbound word
  // the frame bits are part of the checksum, so they are
  // placed before the nibbles are folded
  wire [1:0] frame_ok = 2'b01;
  wire [31:0] rsp_body =
    {4'h0, frame_ok, st, req_reg_reg, rsp_data};
  wire [31:0] rsp_full = {mcr_cks(rsp_body), rsp_body[27:0]};
  // answer to a damaged command: error flag set, no body
  wire [31:0] err_body = 32'h0c000000;
  wire [31:0] err_word = {mcr_cks(err_body), err_body[27:0]};

  ////////////////////////////////////////////////////////////////
  // what the response register loads next
  // a replay sends the last good answer unchanged
  wire rsp_load = res_take || (cmd_take && (!cks_ok || resend));
  wire [31:0] rsp_pick = res_take ? rsp_full :
    !cks_ok ? err_word :
    last_rsp_reg;

  // slot allocate on pending answer, release on done
  // a release and a new allocation may fall in one cycle
  assign busy_next = (busy_reg & ~pend_done) |
    ((res_take && use_pend) ? free_pick : 8'h00);

  ////////////////////////////////////////////////////////////////
  // pending slot bookkeeping
  // the port mirrors the slots held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_reg <= 8'h00;
      pend_busy <= 8'h00;
    end else if (ce) begin
      busy_reg <= busy_next;
      pend_busy <= busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // one command outstanding; later commands are dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_reg <= 1'b0;
    end else if (ce) begin
      if (cmd_good) begin
        wait_reg <= 1'b1;
      end else if (res_take) begin
        wait_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // request to the user side, a one-cycle strobe
  // the fields stand until the next accepted command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_valid <= 1'b0;
      req_write <= 1'b0;
      req_reg <= 8'h00;
      req_data <= ID_RESET;
      req_pend_id <= 8'h00;
      req_reg_reg <= 8'h00;
    end else if (ce) begin
      req_valid <= cmd_good; // bits 26:25 ignored
      if (cmd_good) begin
        req_write <= is_write;
        req_reg <= cmd_reg; // reg 0x0b passed to user side
        req_data <= cmd_data;
        req_pend_id <= free_pick;
        req_reg_reg <= cmd_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // response register and replay copy
  // the replay copy holds only answers to good commands
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_reg <= WORD_RESET;
      rsp_valid_reg <= 1'b0;
      last_rsp_reg <= WORD_RESET;
    end else if (ce) begin
      rsp_valid_reg <= rsp_load;
      if (rsp_load) begin
        rsp_reg <= rsp_pick;
      end
      if (res_take) begin
        last_rsp_reg <= rsp_full;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // id handed out with the latest answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_id_reg <= 8'h00;
    end else if (ce && res_take) begin
      pend_id_reg <= use_pend ? free_pick : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // one-cycle flag for a damaged inbound word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cks_err <= 1'b0;
    end else if (ce) begin
      cks_err <= cmd_take && !cks_ok;
    end
  end

  ////////////////////////////////////////////////////////////////
  // link outputs come straight from the registers
  assign link.rsp_valid = rsp_valid_reg;
  assign link.rsp_word = rsp_reg;
endmodule // mcr_dev

// file: src/mcr_host.sv
// Purpose: host end; AHB-Lite registers drive command words
// Assumes: one outstanding command
// Notes: sticky status bits raise a level interrupt
module mcr_host import mcr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  mcr_if.host link,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq
);
  logic [31:0] cmd_reg_q;
  logic [31:0] rsp_q;
  logic [3:0] stat_reg;
  logic [3:0] ien_reg;
  logic busy_reg;
  logic cv_reg;
  logic wr_reg;
  logic [7:0] addr_reg;

  ////////////////////////////////////////////////////////////////
  // address phase capture
  wire ap = ce && hsel && hready && htrans[1];
  wire [31:0] cmd_pl = {4'h0, 28'(hwdata[27:0])};
  wire [31:0] cmd_ck = {mcr_cks(cmd_pl), cmd_pl[27:0]};
  wire dp_wr = ce && wr_reg;
  wire send = dp_wr && addr_reg == HOFF_CMD && !busy_reg;
  wire got = ce && link.rsp_valid;
  wire [1:0] rst_st = link.rsp_word[STAT_HI:STAT_LO];
  // events: done, exec error, pending, checksum error
  wire [3:0] ev = got ? {link.rsp_word[CKS_HI:CKS_LO] !=
    mcr_cks(link.rsp_word), rst_st == 2'h3, rst_st == 2'h1, 1'b1}
    : 4'h0;
  wire [3:0] clr = (dp_wr && addr_reg == HOFF_ICLR) ? hwdata[3:0] : 4'h0;
  // read data chosen in the address phase, so it stands in the data phase
  wire [31:0] rd_mux = (haddr == HOFF_CMD) ? cmd_reg_q :
    (haddr == HOFF_RSP) ? rsp_q :
    (haddr == HOFF_STAT) ? {27'h0, busy_reg, stat_reg} :
    (haddr == HOFF_IEN) ? {28'h0, ien_reg} : 32'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_reg_q <= WORD_RESET;
      rsp_q <= WORD_RESET;
      stat_reg <= 4'h0;
      ien_reg <= 4'h0;
      busy_reg <= 1'b0;
      cv_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata <= WORD_RESET;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      wr_reg <= ap && hwrite;
      if (ap) addr_reg <= haddr;
      cv_reg <= send;
      if (send) begin
        cmd_reg_q <= cmd_ck;
        busy_reg <= 1'b1;
      end
      if (dp_wr && addr_reg == HOFF_IEN) ien_reg <= hwdata[3:0];
      if (got) begin
        rsp_q <= link.rsp_word;
        busy_reg <= 1'b0;
      end
      stat_reg <= (stat_reg & ~clr) | ev; // set wins
      irq <= |(((stat_reg & ~clr) | ev) & ien_reg);
      if (ap && !hwrite) hrdata <= rd_mux;
    end
  end

  assign link.cmd_valid = cv_reg;
  assign link.cmd_word = cmd_reg_q;
endmodule // mcr_host

// file: sim/mcr_link_props.sv
// Purpose: checks on the word link between host end and module end
// Assumes: one clock, synchronous active-low reset
// Notes: sees only the shared link signals
module mcr_link_props import mcr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_word,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] last_reg_reg;
  // nibble fold of the low 28 bits
  function automatic logic [3:0] fold(input logic [31:0] w);
    fold = w[27:24] ^ w[23:20] ^ w[19:16] ^ w[15:12];
    fold = fold ^ w[11:8] ^ w[7:4] ^ w[3:0];
  endfunction
  // register number of the last command
  always_ff @(posedge clk) begin
    if (!rst_n) last_reg_reg <= 8'h00;
    else if (cmd_valid) last_reg_reg <= cmd_word[23:16];
  end
  sequence pend_rsp;
    rsp_valid && rsp_word[25:24] == 2'h3;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  cmd_top_a: assert property (cmd_valid |-> cmd_word[27] == 1'b0)
    else $error("command top bit set");
  cmd_cks_a: assert property (cmd_valid |-> cmd_word[31:28] == fold(cmd_word))
    else $error("command checksum wrong");
  rsp_cks_a: assert property (rsp_valid |-> rsp_word[31:28] == fold(rsp_word))
    else $error("response checksum wrong");
  rsp_frame_a: assert property (rsp_valid |-> rsp_word[27:26] == 2'b01)
    else $error("response frame bits wrong");
  rsp_reg_a: assert property (rsp_valid |-> rsp_word[23:16] == last_reg_reg)
    else $error("response register not echoed");
  pend_id_a: assert property (pend_rsp |-> rsp_word[7:0] == 8'h00
    && $onehot(rsp_word[15:8])) else $error("pending id malformed");
  cmd_gap_a: assert property (cmd_valid |=> !cmd_valid [*3])
    else $error("commands too close");
  cmd_hold_a: assert property ($changed(cmd_word) |-> cmd_valid)
    else $error("command word moved without valid");
  rsp_hold_a: assert property ($changed(rsp_word) |-> rsp_valid)
    else $error("response word moved without valid");
endmodule // mcr_link_props

// file: sim/tb_module_command_response_packet.sv
// Purpose: drives both ends through the host bus and the user side
// Assumes: zero-wait slave, one outstanding command
// Notes: random commands with fixed corner kinds first
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_module_command_response_packet import mcr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, hsel, hwrite, hrdy, hresp, irq, res_valid, res_error;
  logic res_pending, res_auto_ext, req_valid, req_write, wr;
  logic [7:0] haddr, rg, exp_busy, id, pend_done, pend_busy, req_reg;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [15:0] dt, rd, res_data, req_data;
  logic [25:0] msk;
  int kind, num_errors, n_compared;
  mcr_if lnk();
  mcr_host i_mcr_host (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(lnk),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .irq(irq));
  mcr_dev i_mcr_dev (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(lnk),
    .req_valid(req_valid), .req_write(req_write), .req_reg(req_reg),
    .req_data(req_data), .req_pend_id(), .cks_err(), .res_valid(res_valid),
    .res_error(res_error), .res_pending(res_pending), .res_data(res_data),
    .res_auto_ext(res_auto_ext), .pend_done(pend_done),
    .pend_busy(pend_busy));
  mcr_link_props i_mcr_link_props (.clk(clk), .rst_n(rst_n),
    .cmd_valid(lnk.cmd_valid), .cmd_word(lnk.cmd_word),
    .rsp_valid(lnk.rsp_valid), .rsp_word(lnk.rsp_word));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [25:0] exp_rsp(input int k, input logic [15:0] d);
    case (k)
      1: return {2'h1, rg, d};
      2: return {2'h2, rg, d};
      3: return {2'h3, rg, id, 8'h00};
      4: return {2'h2, rg, id, d[7:0]};
      default: return {2'h0, rg, d};
    endcase
  endfunction
  function automatic logic [3:0] fold(input logic [31:0] w);
    fold = w[27:24] ^ w[23:20] ^ w[19:16] ^ w[15:12];
    fold = fold ^ w[11:8] ^ w[7:4] ^ w[3:0];
  endfunction
  // one single word transfer, entered just after a clock edge
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hsize <= 3'h2;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  // user side: checks the decode, answers after a random delay
  initial forever begin
    @(posedge clk);
    if (req_valid === 1'b1) begin
      `CHK("req", {wr, rg, dt}, {req_write, req_reg, req_data})
      repeat ($urandom_range(0, 3)) @(posedge clk);
      res_valid <= 1'b1;
      res_error <= kind == 1;
      res_pending <= kind > 2;
      res_auto_ext <= kind == 2 || kind == 4;
      res_data <= rd;
      @(posedge clk);
      res_valid <= 1'b0;
    end
  end
  // main sequence
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata, res_data, pend_done} = '0;
    {res_valid, res_error, res_pending, res_auto_ext, rst_n} = '0;
    {num_errors, n_compared, exp_busy, kind} = '0;
    void'($urandom(98117));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 40; i++) begin
      kind = (i < 5) ? i : $urandom_range(0, 4);
      rg = 8'($urandom_range(12, 255));
      {wr, dt, rd} = 33'($urandom) ^ {33'($urandom) << 16};
      pend_done <= (exp_busy == 8'hff) ? 8'hff : exp_busy & 8'($urandom);
      @(posedge clk);
      exp_busy = exp_busy & ~pend_done;
      pend_done <= 8'h00;
      id = ~exp_busy & (exp_busy + 8'h01);
      ahb(1'b1, HOFF_IEN, {31'h0, i[0]});
      ahb(1'b1, HOFF_CMD, {7'h0, wr, rg, dt});
      q = '0;
      for (int k = 0; k < 50 && q[0] !== 1'b1; k++) ahb(1'b0, HOFF_STAT, '0);
      `CHK("irq", i[0], irq)
      ahb(1'b0, HOFF_RSP, '0);
      msk = (kind == 1) ? 26'h3ff0000 : 26'h3ffffff;
      `CHK("rsp", exp_rsp(kind, rd) & msk, q[25:0] & msk)
      `CHK("frame", 2'b01, q[27:26])
      `CHK("cks", fold(q), q[31:28])
      if (kind > 2) exp_busy = exp_busy | id;
      `CHK("busy", exp_busy, pend_busy)
      ahb(1'b1, HOFF_ICLR, 32'h0000001f);
      repeat (2) @(posedge clk);
      `CHK("irq_clr", 1'b0, irq)
    end
    ahb(1'b0, 8'h20, '0);
    `CHK("unmapped", 32'h00000000, q)
    tally_and_finish();
  end
endmodule // tb_module_command_response_packet
